// [rtl/cbi_pkg.sv]
// Functional notes
// - Bus cycle spans T1..T4 at minimum
// - Address in T1, data in T3/T4
// - Not ready adds waits between T3, T4
// - Idle states allowed between bus cycles
// - Address latch pulse in every T1 in minimum mode
// - Low, high lines multiplexed; middle held
// - Twenty-bit linear byte address
// - Four segment bases, 16-byte aligned
// - Prefetch always uses code base
// - Stack base for stack, pointer references
// - Extra base for string destination, no override
// - Four-byte prefetch queue, first in first out
// - Fetch a byte whenever queue has room
// - Empty queue passes first byte at once
// - Word operand runs two byte cycles
// - Low byte lower address, high next
// - Start fetching at top vector after reset
// - Lowest region reserved for interrupt pointers
// - Strap selects minimum or maximum mode
// - Maximum mode: status, lock, queue status
// - Fully static state, clock may stop
// - Three status lines encode cycle type
// - Upper status bits report segment used
package cbi_pkg;
	// Widths and sizes
	localparam int BYTE_W      = 8;
	localparam int QUEUE_BYTES = 4;
	// Reset start point
	localparam logic [15:0] RESET_CODE_BASE = 16'hffff;
	localparam logic [15:0] RESET_IP        = 16'h0000;
	// Interrupt pointer table end
	localparam logic [19:0] VEC_TABLE_TOP   = 20'h003ff;
	// Upper lines during port cycles
	localparam logic [3:0]  IO_HIGH         = 4'h0;
	// Fixed upper status bit
	localparam logic        S6_LEVEL        = 1'b0;
	// Queue status codes
	localparam logic [1:0]  QS_NONE  = 2'h0;
	localparam logic [1:0]  QS_FIRST = 2'h1;
	localparam logic [1:0]  QS_EMPTY = 2'h2;
	localparam logic [1:0]  QS_NEXT  = 2'h3;
	// Bus states, one bit changes per step except T3 to T4 and T4 to T1
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_T1 = 3'h1, ST_T2 = 3'h3,
		ST_T3 = 3'h2, ST_TW = 3'h6, ST_T4 = 3'h4
	} cbi_state_type;
	// Cycle status codes
	typedef enum logic [2:0] {
		CYC_INTA = 3'h0, CYC_IO_RD = 3'h1, CYC_IO_WR = 3'h2,
		CYC_HALT = 3'h3, CYC_FETCH = 3'h4, CYC_MEM_RD = 3'h5,
		CYC_MEM_WR = 3'h6, CYC_PASSIVE = 3'h7
	} cbi_cyc_type;
	// Segment select, also upper status code
	typedef enum logic [1:0] {
		SEG_EXTRA = 2'h0, SEG_STACK = 2'h1, SEG_CODE = 2'h2, SEG_DATA = 2'h3
	} cbi_seg_type;
	// Operand reference kinds
	typedef enum logic [1:0] {
		REF_DATA = 2'h0, REF_STACK = 2'h1, REF_STR_DEST = 2'h2, REF_OVERRIDE = 2'h3
	} cbi_ref_type;

	// Base shifted four plus offset, 20 bits
	function automatic logic [19:0] phys_addr(input logic [15:0] base, input logic [15:0] off);
		phys_addr = {base, 4'h0} + {4'h0, off};
	endfunction

	// Segment picked for an operand
	function automatic cbi_seg_type seg_for(input cbi_ref_type kind, input cbi_seg_type ovr);
		case (kind)
			REF_STACK:    seg_for = SEG_STACK;
			REF_STR_DEST: seg_for = SEG_EXTRA;
			REF_OVERRIDE: seg_for = ovr;
			default:      seg_for = SEG_DATA;
		endcase
	endfunction
endpackage

// [rtl/cbi_q_if.sv]
`timescale 1ns/1ps
// Link between unit and its byte store
interface cbi_q_if #(
	parameter int DEPTH = 3,
	parameter int WIDTH = 8
);
	logic                       push;        // Store a byte
	logic [WIDTH-1:0]           push_byte;   // Byte to store
	logic                       pop;         // Drop front byte
	logic                       flush;       // Empty the store
	logic [WIDTH-1:0]           front_byte;  // Oldest byte
	logic                       front_valid; // Store not empty
	logic [$clog2(DEPTH+1)-1:0] count;       // Bytes held
	modport store (input push, push_byte, pop, flush, output front_byte, front_valid, count);
	modport user (output push, push_byte, pop, flush, input front_byte, front_valid, count);
endinterface

// [rtl/cbi_byte_fifo.sv]
`timescale 1ns/1ps
// Byte store behind the queue head
module cbi_byte_fifo
	import cbi_pkg::*;
#(
	parameter int DEPTH = QUEUE_BYTES - 1,
	parameter int WIDTH = BYTE_W
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Unit side
	cbi_q_if.store   q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH]; // Stored bytes
	logic [PW-1:0]    wr_reg;          // Write pointer
	logic [PW-1:0]    rd_reg;          // Read pointer
	logic [CW-1:0]    cnt_reg;         // Fill level
	logic             do_push;         // Accepted store
	logic             do_pop;          // Accepted drop

	// Pointer step with wrap
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign do_pop        = q.pop && (cnt_reg != '0);
	assign do_push       = q.push && ((cnt_reg != CW'(DEPTH)) || do_pop);
	assign q.front_byte  = mem_reg[rd_reg];
	assign q.front_valid = (cnt_reg != '0);
	assign q.count       = cnt_reg;

	// Byte storage
	always_ff @(posedge clock)
	begin
		if (do_push)
			mem_reg[wr_reg] <= q.push_byte;
	end

	// Pointers and level, flush wins
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else if (q.flush)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (do_push)
				wr_reg <= bump(wr_reg);
			if (do_pop)
				rd_reg <= bump(rd_reg);
			cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule

// [rtl/cbi_bus_unit.sv]
`timescale 1ns/1ps
// Bus cycles, prefetch queue, address relocation
module cbi_bus_unit
	import cbi_pkg::*;
#(
	parameter int QUEUE_DEPTH = QUEUE_BYTES // Prefetch bytes
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// Configuration strap, high for minimum mode
	input  wire logic        mode_strap,
	// Operand request from execution unit
	input  wire logic        eu_req,
	input  wire logic        eu_write,
	input  wire logic        eu_word,
	input  wire logic        eu_io,
	input  cbi_ref_type      eu_ref,
	input  cbi_seg_type      eu_override,
	input  wire logic [15:0] eu_offset,
	input  wire logic [15:0] eu_wdata,
	output logic             eu_done_reg,
	output logic [15:0]      eu_rdata_reg,
	// Segment loads and branches
	input  wire logic        seg_load,
	input  cbi_seg_type      seg_load_sel,
	input  wire logic [15:0] seg_load_val,
	input  wire logic        branch,
	input  wire logic [15:0] branch_ip,
	// Instruction byte stream
	input  wire logic        q_take,
	input  wire logic        q_take_first,
	output logic             q_valid_reg,
	output logic [7:0]       q_byte_reg,
	// Processor flags
	input  wire logic        ie_flag,
	input  wire logic        eu_lock,
	// Bus lines
	input  wire logic [7:0]  lad_in,
	output logic [7:0]       lad_out_reg,
	output logic             lad_oe_reg,
	output logic [7:0]       mid_addr_reg,
	output logic [3:0]       high_as_reg,
	input  wire logic        ready,
	// Bus control
	output logic             ale_reg,
	output cbi_cyc_type      cyc_status_reg,
	output logic             rd_b_reg,
	output logic             wr_b_reg,
	output logic             io_m_reg,
	output logic             dt_r_reg,
	output logic             den_b_reg,
	output logic             lock_b_reg,
	output logic [1:0]       qs_reg,
	output logic             vec_region_reg
);
	// Bus sequencer
	cbi_state_type state_reg;    // Current bus state
	cbi_state_type state_next;   // Next bus state
	// Segment bases and fetch pointer
	logic [15:0]   seg_reg [4];  // Four bases
	logic [15:0]   ip_reg;       // Next fetch offset
	// Strap capture
	logic          mode_min_reg; // Minimum mode
	logic          mode_done_reg;// Strap caught
	// Running cycle
	logic [19:0]   cyc_addr_reg; // Byte address
	cbi_cyc_type   cyc_kind_reg; // Cycle type
	cbi_seg_type   cyc_seg_reg;  // Segment used
	logic [7:0]    cyc_data_reg; // Write byte
	logic          cyc_last_reg; // Last byte of operand
	logic          discard_reg;  // Fetch made stale
	logic          op_hi_reg;    // Second byte of word
	logic          first_reg;    // No cycle since reset
	// Selection
	logic [15:0]   op_off;       // Operand byte offset
	logic [19:0]   sel_addr;     // Chosen address
	cbi_cyc_type   sel_kind;     // Chosen type
	cbi_seg_type   sel_seg;      // Chosen segment
	logic [7:0]    sel_data;     // Chosen write byte
	logic [19:0]   addr_d;       // Address for next state
	cbi_cyc_type   kind_d;       // Type for next state
	cbi_seg_type   seg_d;        // Segment for next state
	logic [7:0]    data_d;       // Data for next state
	// Control terms
	logic          in_cycle;     // T1 through waits
	logic          op_busy;      // Operand cycle running
	logic          op_want;      // Operand pending
	logic          inflight;     // Fetch not yet stored
	logic [2:0]    occ;          // Queue bytes claimed
	logic          room;         // Queue has space
	logic          go;           // Start a cycle
	logic          load;         // Entering T1
	logic          xfer;         // Data taken this edge
	logic          push;         // Fetched byte kept
	logic          head_free;    // Head may refill
	logic          wr_d;         // Next cycle writes

	cbi_q_if #(.DEPTH(QUEUE_DEPTH - 1), .WIDTH(BYTE_W)) q ();

	// Remaining queue bytes
	cbi_byte_fifo #(
		.DEPTH (QUEUE_DEPTH - 1),
		.WIDTH (BYTE_W)
	) u_fifo (
		.clock (clock),
		.rst_b (rst_b),
		.q     (q.store)
	);

	// Write cycle test
	function automatic logic is_write(input cbi_cyc_type k);
		is_write = (k == CYC_IO_WR) || (k == CYC_MEM_WR);
	endfunction

	// Cycle bookkeeping terms
	always_comb
	begin
		in_cycle  = state_reg inside {ST_T1, ST_T2, ST_T3, ST_TW};
		op_busy   = in_cycle && (cyc_kind_reg != CYC_FETCH);
		op_want   = eu_req && !eu_done_reg && !op_busy;
		inflight  = in_cycle && (cyc_kind_reg == CYC_FETCH) && !discard_reg;
		occ       = {2'h0, q_valid_reg} + {1'b0, q.count} + {2'h0, inflight};
		room      = occ < 3'(QUEUE_DEPTH);
		go        = mode_done_reg && (op_want || room);
		xfer      = ((state_reg == ST_T3) || (state_reg == ST_TW)) && ready;
		push      = xfer && (cyc_kind_reg == CYC_FETCH) && !discard_reg && !branch;
		head_free = !q_valid_reg || q_take;
	end

	// Next cycle choice, operands first
	always_comb
	begin
		op_off = eu_offset + {15'h0, op_hi_reg};
		if (op_want)
		begin
			sel_seg  = eu_io ? SEG_CODE : seg_for(eu_ref, eu_override);
			if (eu_io)
				sel_kind = eu_write ? CYC_IO_WR : CYC_IO_RD;
			else
				sel_kind = eu_write ? CYC_MEM_WR : CYC_MEM_RD;
			sel_addr = eu_io ? {IO_HIGH, op_off} : phys_addr(seg_reg[sel_seg], op_off);
			sel_data = op_hi_reg ? eu_wdata[15:8] : eu_wdata[7:0];
		end
		else
		begin
			sel_seg  = SEG_CODE;
			sel_kind = CYC_FETCH;
			sel_addr = phys_addr(seg_reg[SEG_CODE], ip_reg);
			sel_data = 8'h00;
		end
	end

	// Bus state sequence
	always_comb
	begin
		case (state_reg)
			ST_IDLE: state_next = go ? ST_T1 : ST_IDLE;
			ST_T1:   state_next = ST_T2;
			ST_T2:   state_next = ST_T3;
			ST_T3:   state_next = ready ? ST_T4 : ST_TW;
			ST_TW:   state_next = ready ? ST_T4 : ST_TW;
			ST_T4:   state_next = go ? ST_T1 : ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		load   = (state_next == ST_T1);
		addr_d = load ? sel_addr : cyc_addr_reg;
		kind_d = load ? sel_kind : cyc_kind_reg;
		seg_d  = load ? sel_seg : cyc_seg_reg;
		data_d = load ? sel_data : cyc_data_reg;
		wr_d   = is_write(kind_d);
	end

	// State register, static hold between edges
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Strap caught once after reset release
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_min_reg  <= 1'b0;
			mode_done_reg <= 1'b0;
		end
		else if (!mode_done_reg)
		begin
			mode_min_reg  <= mode_strap;
			mode_done_reg <= 1'b1;
		end
	end

	// Segment bases, code base set for start vector
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seg_reg[SEG_EXTRA] <= 16'h0000;
			seg_reg[SEG_STACK] <= 16'h0000;
			seg_reg[SEG_CODE]  <= RESET_CODE_BASE;
			seg_reg[SEG_DATA]  <= 16'h0000;
		end
		else if (seg_load)
			seg_reg[seg_load_sel] <= seg_load_val;
	end

	// Fetch pointer, branch restarts it
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ip_reg <= RESET_IP;
		else if (branch)
			ip_reg <= branch_ip;
		else if (load && !op_want)
			ip_reg <= ip_reg + 16'h0001;
	end

	// Latched cycle description
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cyc_addr_reg <= 20'h00000;
			cyc_kind_reg <= CYC_PASSIVE;
			cyc_seg_reg  <= SEG_CODE;
			cyc_data_reg <= 8'h00;
			cyc_last_reg <= 1'b0;
			discard_reg  <= 1'b0;
			first_reg    <= 1'b1;
		end
		else if (load)
		begin
			cyc_addr_reg <= sel_addr;
			cyc_kind_reg <= sel_kind;
			cyc_seg_reg  <= sel_seg;
			cyc_data_reg <= sel_data;
			cyc_last_reg <= op_want && (!eu_word || op_hi_reg);
			discard_reg  <= branch && !op_want;
			first_reg    <= 1'b0;
		end
		else if (branch && in_cycle)
			discard_reg <= 1'b1; // Old stream byte
	end

	// Operand completion, two bytes for words
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op_hi_reg    <= 1'b0;
			eu_done_reg  <= 1'b0;
			eu_rdata_reg <= 16'h0000;
		end
		else
		begin
			eu_done_reg <= xfer && op_busy && cyc_last_reg;
			if (xfer && op_busy)
			begin
				op_hi_reg <= !cyc_last_reg;
				if (!is_write(cyc_kind_reg) && op_hi_reg)
					eu_rdata_reg[15:8] <= lad_in;
				else if (!is_write(cyc_kind_reg))
					eu_rdata_reg[7:0] <= lad_in;
			end
		end
	end

	// Queue store control
	always_comb
	begin
		q.flush     = branch;
		q.pop       = head_free && !branch && q.front_valid;
		q.push      = push && !(head_free && !q.front_valid);
		q.push_byte = lad_in;
	end

	// Queue head, bypass when empty
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q_valid_reg <= 1'b0;
			q_byte_reg  <= 8'h00;
		end
		else if (branch)
			q_valid_reg <= 1'b0;
		else if (head_free)
		begin
			if (q.front_valid)
				q_byte_reg <= q.front_byte;
			else if (push)
				q_byte_reg <= lad_in;
			q_valid_reg <= q.front_valid || push;
		end
	end

	// Queue status and lock lines
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			qs_reg     <= QS_NONE;
			lock_b_reg <= 1'b1;
		end
		else
		begin
			lock_b_reg <= !(eu_lock && !mode_min_reg);
			if (mode_min_reg)
				qs_reg <= QS_NONE;
			else if (branch)
				qs_reg <= QS_EMPTY;
			else if (q_take && q_valid_reg)
				qs_reg <= q_take_first ? QS_FIRST : QS_NEXT;
			else
				qs_reg <= QS_NONE;
		end
	end

	// Multiplexed lines per state
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lad_out_reg  <= 8'h00;
			lad_oe_reg   <= 1'b0;
			mid_addr_reg <= 8'h00;
			high_as_reg  <= 4'h0;
		end
		else
		begin
			if (state_next != ST_IDLE)
				mid_addr_reg <= addr_d[15:8];
			case (state_next)
				ST_T1:
				begin
					lad_out_reg <= addr_d[7:0];
					lad_oe_reg  <= 1'b1;
					high_as_reg <= addr_d[19:16];
				end
				ST_T2, ST_T3, ST_TW, ST_T4:
				begin
					lad_out_reg <= data_d;
					lad_oe_reg  <= wr_d;
					high_as_reg <= {S6_LEVEL, ie_flag, seg_d};
				end
				default:
				begin
					lad_oe_reg  <= 1'b0;
					high_as_reg <= 4'h0;
				end
			endcase
		end
	end

	// Strobes and cycle status
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ale_reg        <= 1'b0;
			cyc_status_reg <= CYC_PASSIVE;
			rd_b_reg       <= 1'b1;
			wr_b_reg       <= 1'b1;
			io_m_reg       <= 1'b0;
			dt_r_reg       <= 1'b0;
			den_b_reg      <= 1'b1;
			vec_region_reg <= 1'b0;
		end
		else
		begin
			ale_reg <= load && mode_min_reg;
			if (state_next inside {ST_T1, ST_T2, ST_T3, ST_TW})
				cyc_status_reg <= kind_d;
			else
				cyc_status_reg <= CYC_PASSIVE;
			if (state_next != ST_IDLE)
			begin
				io_m_reg <= !kind_d[2];
				dt_r_reg <= kind_d[1];
			end
			rd_b_reg  <= !(mode_min_reg && !wr_d && (state_next inside {ST_T2, ST_T3, ST_TW}));
			wr_b_reg  <= !(mode_min_reg && wr_d && (state_next inside {ST_T2, ST_T3, ST_TW}));
			den_b_reg <= !(mode_min_reg && (state_next inside {ST_T2, ST_T3, ST_TW}));
			vec_region_reg <= (state_next != ST_IDLE) && kind_d[2] &&
				(addr_d <= VEC_TABLE_TOP);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_cycle_order: assert property (
		state_reg == ST_T1 |=> state_reg == ST_T2 ##1 state_reg == ST_T3)
		else $error("bus cycle states out of order");
	a_wait_hold: assert property (
		(state_reg inside {ST_T3, ST_TW}) && !ready |=> state_reg == ST_TW)
		else $error("wait state missing while not ready");
	a_ready_exit: assert property (
		(state_reg inside {ST_T3, ST_TW}) && ready |=> state_reg == ST_T4)
		else $error("ready seen but no T4");
	a_ale_in_t1: assert property (
		state_reg == ST_T1 |-> ale_reg == mode_min_reg)
		else $error("address latch pulse wrong in T1");
	a_mid_stable: assert property (
		state_reg inside {ST_T2, ST_T3, ST_TW, ST_T4} |-> $stable(mid_addr_reg))
		else $error("middle address moved in cycle");
	a_seg_status: assert property (
		state_reg inside {ST_T2, ST_T3, ST_TW, ST_T4}
		|-> high_as_reg == {S6_LEVEL, $past(ie_flag), cyc_seg_reg})
		else $error("upper status bits wrong");
	a_fetch_code: assert property (
		state_reg == ST_T1 && cyc_kind_reg == CYC_FETCH |-> cyc_seg_reg == SEG_CODE)
		else $error("prefetch not on code base");
	a_queue_bound: assert property (
		occ <= 3'(QUEUE_DEPTH))
		else $error("prefetch queue overfilled");
	a_bypass_empty: assert property (
		!q_valid_reg && push |=> q_valid_reg && q_byte_reg == $past(lad_in))
		else $error("first byte not passed at once");
	a_start_vector: assert property (
		first_reg && load |=> cyc_addr_reg == phys_addr(RESET_CODE_BASE, RESET_IP))
		else $error("first fetch not at start vector");
endmodule

// [bench/cbi_mem_model.sv]
`timescale 1ns/1ps
// Memory, ports and address latch on the far side of the bus
module cbi_mem_model
	import cbi_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// Lines from the unit
	input  wire logic [7:0] lad_out,
	input  wire logic       lad_oe,
	input  wire logic [7:0] mid_addr,
	input  wire logic [3:0] high_as,
	input  cbi_cyc_type     cyc_status,
	// Answer to the unit
	input  wire logic [2:0] waits,
	output logic [7:0]      lad_in,
	output logic            ready,
	// Record of each finished cycle
	output logic            rec_stb,
	output logic [19:0]     rec_addr,
	output cbi_cyc_type     rec_type,
	output logic [2:0]      rec_seg,
	output logic [7:0]      rec_data,
	output logic [3:0]      rec_len
);
	cbi_cyc_type prev_reg; // Status one clock back
	logic [3:0]  ph_reg;   // Clocks done in cycle
	logic [7:0]  hold_reg; // Last level on data lines
	logic        drv;      // Read data on the lines
	// Pattern held at each address
	function automatic logic [7:0] mem(input logic [19:0] a);
		mem = a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction
	// Drive only after turnaround of a read
	assign drv = !lad_oe && ph_reg >= 4'h2 &&
		rec_type inside {CYC_IO_RD, CYC_FETCH, CYC_MEM_RD};
	// Released lines flip every clock
	assign lad_in = drv ? mem(rec_addr) : ~hold_reg;
	// Not ready for the asked number of waits
	assign ready = !(cyc_status != CYC_PASSIVE && ph_reg >= 4'h2 &&
		ph_reg < 4'(waits) + 4'h2);
	// Follow the cycle from the status lines
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
		begin
			prev_reg <= CYC_PASSIVE;
			ph_reg   <= 4'h0;
			hold_reg <= 8'h00;
			rec_stb  <= 1'b0;
		end
		else
		begin
			prev_reg <= cyc_status;
			hold_reg <= lad_in;
			rec_stb  <= 1'b0;
			// T1 ends: latch address and decode type
			if (cyc_status != CYC_PASSIVE && prev_reg == CYC_PASSIVE)
			begin
				rec_addr <= {high_as, mid_addr, lad_out};
				rec_type <= cyc_status;
				ph_reg   <= 4'h1;
			end
			else if (cyc_status != CYC_PASSIVE)
			begin
				ph_reg <= ph_reg + 4'h1;
				if (ph_reg == 4'h1)
					rec_seg <= high_as[2:0];
				if (ph_reg == 4'h2)
					rec_data <= drv ? mem(rec_addr) : lad_out;
			end
			// T4 ends: cycle complete
			else if (prev_reg != CYC_PASSIVE)
			begin
				rec_stb <= 1'b1;
				rec_len <= ph_reg + 4'h1;
				ph_reg  <= 4'h0;
			end
		end
endmodule

// [bench/cbi_bus_unit_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the bus unit
module cbi_bus_unit_tb_top;
	import cbi_pkg::*;
	logic        clock, rst_b, mode_strap, eu_req, eu_write, eu_word, eu_io, eu_done;
	logic        seg_load, branch, q_take, q_take_first, q_valid, ie_flag, eu_lock;
	logic        lad_oe, ready, ale, rd_b, wr_b, lock_b, rec_stb, io_m, dt_r, den_b, vec;
	cbi_ref_type eu_ref;
	cbi_seg_type eu_override, seg_load_sel;
	cbi_cyc_type cyc_status, rec_type;
	logic [15:0] eu_offset, eu_wdata, eu_rdata, seg_load_val, branch_ip;
	logic [7:0]  q_byte, lad_in, lad_out, mid, rec_data;
	logic [3:0]  high, rec_len;
	logic [2:0]  waits, rec_seg;
	logic [1:0]  qs;        // Queue status seen
	logic [19:0] rec_addr;
	logic [15:0] base [4];  // Segment bases loaded
	logic [37:0] recs [$];  // {len, type, seg, addr, data}
	int          failures, cmp_count, cyc_cnt;

	cbi_bus_unit u_dut (.clock(clock), .rst_b(rst_b), .mode_strap(mode_strap),
		.eu_req(eu_req), .eu_write(eu_write), .eu_word(eu_word), .eu_io(eu_io),
		.eu_ref(eu_ref), .eu_override(eu_override), .eu_offset(eu_offset),
		.eu_wdata(eu_wdata), .eu_done_reg(eu_done), .eu_rdata_reg(eu_rdata),
		.seg_load(seg_load), .seg_load_sel(seg_load_sel), .seg_load_val(seg_load_val),
		.branch(branch), .branch_ip(branch_ip), .q_take(q_take),
		.q_take_first(q_take_first), .q_valid_reg(q_valid), .q_byte_reg(q_byte),
		.ie_flag(ie_flag), .eu_lock(eu_lock), .lad_in(lad_in), .lad_out_reg(lad_out),
		.lad_oe_reg(lad_oe), .mid_addr_reg(mid), .high_as_reg(high), .ready(ready),
		.ale_reg(ale), .cyc_status_reg(cyc_status), .rd_b_reg(rd_b), .wr_b_reg(wr_b),
		.io_m_reg(io_m), .dt_r_reg(dt_r), .den_b_reg(den_b), .lock_b_reg(lock_b), .qs_reg(qs),
		.vec_region_reg(vec));
	cbi_mem_model u_mem (.clock(clock), .rst_b(rst_b), .lad_out(lad_out),
		.lad_oe(lad_oe), .mid_addr(mid), .high_as(high), .cyc_status(cyc_status),
		.waits(waits), .lad_in(lad_in), .ready(ready), .rec_stb(rec_stb),
		.rec_addr(rec_addr), .rec_type(rec_type), .rec_seg(rec_seg),
		.rec_data(rec_data), .rec_len(rec_len));

	// Clock, 5 ns period
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Hang guard
	always @(posedge clock)
	begin
		cyc_cnt++;
		if (cyc_cnt == 60000)
		begin
			failures++;
			end_sim();
		end
	end
	// Collect finished cycles away from the edge
	always @(negedge clock)
		if (rec_stb === 1'b1)
			recs.push_back({rec_len, rec_type, rec_seg, rec_addr, rec_data});

	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Expected memory pattern
	function automatic logic [7:0] mem(input logic [19:0] a);
		mem = a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction
	// Expected segment of the current operand
	function automatic cbi_seg_type es;
		es = SEG_DATA;
		if (eu_io)
			es = SEG_CODE;
		else if (eu_ref == REF_STACK)
			es = SEG_STACK;
		else if (eu_ref == REF_STR_DEST)
			es = SEG_EXTRA;
		else if (eu_ref == REF_OVERRIDE)
			es = eu_override;
	endfunction
	// Expected address of operand byte n
	function automatic logic [19:0] ea(input int n);
		logic [15:0] o;
		o = eu_offset + 16'(n);
		ea = eu_io ? {4'h0, o} : {base[es()], 4'h0} + {4'h0, o};
	endfunction
	// Take the queue head and compare it
	task automatic take(input logic [19:0] a);
		for (int i = 0; i < 100 && q_valid !== 1'b1; i++)
			tick();
		chk("queue byte", mem(a), q_byte);
		q_take = 1'b1;
		tick();
		chk("qs", mode_strap ? QS_NONE : (q_take_first ? QS_FIRST : QS_NEXT), qs);
		q_take = 1'b0;
		tick();
	endtask
	// One operand transfer, then check its byte cycles
	task automatic do_op;
		int          n, lw, lr, ld;
		logic [15:0] rd;
		recs.delete();
		{lw, lr, ld} = '0;
		eu_req = 1'b1;
		// Count strobe-low clocks until the done pulse
		for (int i = 0; i < 300 && eu_done !== 1'b1; i++)
		begin
			tick();
			lw += !wr_b;
			lr += !rd_b;
			ld += !den_b;
		end
		chk("io_m", eu_io, io_m);
		chk("dt_r", eu_write, dt_r);
		chk("vec region", !eu_io && (ea(eu_word) <= VEC_TABLE_TOP), vec);
		eu_req = 1'b0;
		repeat (3) tick();
		n = 0;
		rd = 16'h0000;
		foreach (recs[i])
			if (recs[i][33:31] != CYC_FETCH)
			begin
				chk("addr", ea(n), recs[i][27:8]);
				chk("type", {!eu_io, eu_write, !eu_write}, recs[i][33:31]);
				chk("seg", {ie_flag, es()}, recs[i][30:28]);
				chk("len", 4 + waits, recs[i][37:34]);
				if (eu_write)
					chk("wdata", eu_wdata[8*n+:8], recs[i][7:0]);
				rd[8*n+:8] = mem(ea(n));
				n++;
			end
		chk("byte cycles", eu_word ? 2 : 1, n);
		chk("wr low", eu_write ? (1 + eu_word) * (2 + waits) : 0, lw);
		chk("rd low", eu_write ? 0 : (1 + eu_word) * (2 + waits), lr);
		chk("den low", (1 + eu_word) * (2 + waits), ld);
		if (!eu_write)
			chk("rdata", eu_word ? rd : rd[7:0], eu_word ? eu_rdata : eu_rdata[7:0]);
	endtask

	initial
	begin
		{eu_req, eu_write, eu_word, eu_io, seg_load, branch} = '0;
		{q_take, q_take_first, ie_flag, eu_lock} = '0;
		{eu_offset, eu_wdata, seg_load_val, branch_ip, waits} = '0;
		eu_ref = REF_DATA;
		eu_override = SEG_DATA;
		seg_load_sel = SEG_CODE;
		{failures, cmp_count, cyc_cnt} = '0;
		mode_strap = 1'b1;
		rst_b = 1'b0;
		void'($urandom(32'h6bae3dd2));
		repeat (2) tick();
		chk("reset status", CYC_PASSIVE, cyc_status);
		rst_b = 1'b1;
		repeat (80) tick();
		chk("fill count", 4, recs.size());
		chk("start addr", 20'hffff0, recs[0][27:8]);
		chk("fetch seg", SEG_CODE, recs[0][29:28]);
		chk("fetch len", 4, recs[0][37:34]);
		for (int i = 0; i < 4; i++)
			take(20'hffff0 + 20'(i));
		// Bases, extra base at zero, data base at the top corner
		seg_load = 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			base[s] = (s == 3) ? 16'hffff : (s == 0) ? 16'h0000 : 16'($urandom);
			seg_load_sel = cbi_seg_type'(s);
			seg_load_val = base[s];
			tick();
		end
		seg_load = 1'b0;
		// Let the queue refill so no fetch overlaps an operand
		repeat (20) tick();
		// Random operands, first one wraps the offset
		for (int k = 0; k < 40; k++)
		begin
			{eu_write, eu_word, eu_io, ie_flag, q_take_first} = 5'($urandom);
			eu_io = eu_io & ($urandom_range(3) == 0);
			eu_ref = cbi_ref_type'($urandom_range(3));
			eu_override = cbi_seg_type'($urandom_range(3));
			eu_offset = (k == 0) ? 16'hffff : 16'($urandom);
			eu_wdata = 16'($urandom);
			waits = 3'($urandom_range(3));
			// Corner: operand inside the pointer table
			if (k == 1)
			begin
				eu_io = 1'b0;
				eu_ref = REF_STR_DEST;
				eu_offset = 16'h03fe;
			end
			do_op();
		end
		// Branches into a flushed queue
		for (int k = 0; k < 3; k++)
		begin
			branch_ip = (k == 0) ? 16'hfffe : 16'($urandom);
			branch = 1'b1;
			tick();
			branch = 1'b0;
			take({base[2], 4'h0} + {4'h0, branch_ip});
			take({base[2], 4'h0} + {4'h0, branch_ip + 16'h1});
		end
		// Maximum mode: controller makes strobes
		rst_b = 1'b0;
		mode_strap = 1'b0;
		eu_lock = 1'b1;
		repeat (2) tick();
		rst_b = 1'b1;
		recs.delete();
		repeat (2) tick();
		for (int i = 0; i < 40; i++)
		begin
			tick();
			chk("max ale", 0, ale);
			chk("max rd", 1, rd_b);
			chk("max lock", 0, lock_b);
			chk("max strobes", 2'b11, {wr_b, den_b});
		end
		chk("max cycles", 4, recs.size());
		q_take_first = 1'b1;
		take(20'hffff0);
		q_take_first = 1'b0;
		take(20'hffff1);
		end_sim();
	end
endmodule
